//--- dv/supply_source_model.sv
`timescale 1ns/1ps
module supply_source_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run_req,
   input  wire logic        dip,
   input  wire logic [15:0] nominal,
   input  wire logic [15:0] low,
   output logic             run_cmd,
   output logic [15:0]      bus_volts
);
   // command latched apart from supply, so an outage never drops it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_cmd <= 1'b0;
      else
         run_cmd <= run_req;
   end

   // bus sags to a level below threshold, never to an unknown
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bus_volts <= 16'h0000;
      else
         bus_volts <= dip ? low : nominal;
   end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import plrt_pkg::*;
;
   // short counts keep the run small
   localparam int TICK  = 20;
   localparam int DIP_C = 30;
   localparam int STEP  = 2;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, run_req, dip, search_done, dc_brake_req;
   logic        pready, pslverr, run_cmd, gate_enable, search_start, dc_brake_en;
   logic        undervolt_detect, main_bus_undervolt_fault, irq, rerr;
   logic [7:0]  paddr, volt_ref;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] bus_volts, nominal, low, thr;
   logic [31:0] seed = 32'hbb88;
   int          mismatches = 0;
   int          n_tests = 0;
   int          off_set, ramp_set;

   always #20 pclk = ~pclk;

   supply_source_model u_supply_source_model (
      .pclk(pclk), .presetn(presetn), .run_req(run_req), .dip(dip),
      .nominal(nominal), .low(low), .run_cmd(run_cmd), .bus_volts(bus_volts));

   power_loss_ride_through #(.TICK_CYCLES(TICK), .DIP_CYCLES(DIP_C), .STEP_CYCLES(STEP),
      .HIGH_CLASS(1'b0)) u_power_loss_ride_through (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .run_cmd(run_cmd), .bus_volts(bus_volts),
      .search_done(search_done), .dc_brake_req(dc_brake_req),
      .gate_enable(gate_enable), .search_start(search_start), .dc_brake_en(dc_brake_en),
      .volt_ref(volt_ref), .undervolt_detect(undervolt_detect),
      .main_bus_undervolt_fault(main_bus_undervolt_fault), .irq(irq));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // design outputs are registered, so a read right after the edge is the sampled value
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1);
      chk("pready_wait", 1, n);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdat);
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return gate_enable;
         1: return search_start;
         2: return main_bus_undervolt_fault;
         default: return volt_ref == VREF_MAX;
      endcase
   endfunction

   task automatic wait_hi(input int k, input int lim, output int c);
      c = 0;
      while (sig(k) !== 1'b1 && c < lim)
      begin
         @(posedge pclk);
         c++;
      end
   endtask

   function automatic int exp_fault(input int m, input int ride, input int len);
      if (m == 0)
         return len > DIP_C;
      if (m == 1)
         return len > ride * TICK;
      return 0;
   endfunction

   // lengths stay clear of the exact limits, where the tick phase decides
   task automatic outage(input int m, input int ride, input int len);
      int c, f, g, ef, rmp;
      wr(ADDR_MODE, m);
      wr(ADDR_RIDE, ride);
      wait_hi(0, 300, c);
      ef = exp_fault(m, ride, len);
      f = 0;
      g = 0;
      dip <= 1'b1;
      repeat (len)
      begin
         @(posedge pclk);
         f = f | main_bus_undervolt_fault;
         g = g + !gate_enable;
      end
      chk("undervolt", 1, undervolt_detect);
      chk("gate_dip", m == 0 && ef == 0, gate_enable);
      dip <= 1'b0;
      if (ef == 0 && m != 0)
      begin
         wait_hi(1, 1000, c);
         chk("off_gap", 1, g + c > off_set * TICK);
         chk("vref_start", 0, volt_ref);
         search_done <= 1'b1;
         @(posedge pclk);
         search_done <= 1'b0;
         wait_hi(3, 3000, c);
         rmp = 255 * ramp_set * STEP;
         chk("ramp_len", 1, c >= rmp - 4 && c <= rmp + 8);
         repeat (3) @(posedge pclk);
         chk("gate_back", 1, gate_enable);
         rd(ADDR_STATUS, 32'h0000ff02, "status");
      end
      else if (ef != 0)
      begin
         wait_hi(2, 200, c);
         @(posedge pclk);
         chk("irq_fault", 1, irq);
         wr(ADDR_IRQ_ST, 32'h1);
         repeat (2) @(posedge pclk);
         chk("irq_clear", 0, irq);
         wr(ADDR_CTRL, 32'h1);
         repeat (2) @(posedge pclk);
      end
      else
         repeat (4) @(posedge pclk);
      f = f | main_bus_undervolt_fault;
      chk("fault", ef, f);
      chk("fault_now", 0, main_bus_undervolt_fault);
   endtask

   initial
   begin
      repeat (40000) @(posedge pclk);
      mismatches++;
      complete_run();
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      run_req = 1'b0;
      dip = 1'b0;
      search_done = 1'b0;
      dc_brake_req = 1'b0;
      nominal = UVTHR_RST;
      low = 16'h0000;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_MODE, MODE_RST, "mode");
      rd(ADDR_RIDE, RIDE_RST, "ride");
      rd(ADDR_MINOFF, MINOFF_RST, "minoff");
      rd(ADDR_RECOV, RECOV_RST, "recov");
      rd(ADDR_UVTHR, UVTHR_RST, "uvthr");
      rd(ADDR_IRQ_MSK, 32'h0, "mask");
      wr(8'h24, 32'h5);
      chk("slverr_hole", 1, rerr);
      apb(1'b0, 8'h02, 32'h0);
      chk("slverr_odd", 1, rerr);
      wr(ADDR_RIDE, RIDE_MAX);
      rd(ADDR_RIDE, RIDE_MAX, "ride_max");
      wr(ADDR_UVTHR, 32'h64);
      rd(ADDR_UVTHR, UVTHR_MIN, "uvthr_lo");
      wr(ADDR_UVTHR, 32'h1ff);
      rd(ADDR_UVTHR, UVTHR_MAX, "uvthr_hi");
      wr(ADDR_MINOFF, 32'h0);
      rd(ADDR_MINOFF, MINOFF_MIN, "minoff_lo");
      wr(ADDR_MINOFF, 32'h63);
      rd(ADDR_MINOFF, MINOFF_MAX, "minoff_hi");
      // equal to threshold must count as healthy, one below as low
      thr = UVTHR_MIN + 16'(rnd() % 61);
      nominal <= thr + 16'(rnd() % 30);
      low <= thr - 16'h1 - 16'(rnd() % 100);
      off_set = 1 + rnd() % 3;
      ramp_set = 1 + rnd() % 3;
      wr(ADDR_UVTHR, thr);
      wr(ADDR_MINOFF, off_set);
      wr(ADDR_RECOV, ramp_set);
      wr(ADDR_IRQ_MSK, 32'h1);
      run_req <= 1'b1;
      outage(0, 1, 5 + rnd() % 20);
      outage(0, 1, 45);
      outage(1, 2, 5 + rnd() % 25);
      outage(1, 1, 45);
      outage(1, 0, 5);
      outage(2, 1, 300);
      run_req <= 1'b0;
      dc_brake_req <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("brake_early", 0, dc_brake_en);
      repeat (off_set * TICK + 20) @(posedge pclk);
      chk("brake_late", 1, dc_brake_en);
      rd(ADDR_IRQ_ST, 32'h6, "irq_status");
      chk("irq_masked", 0, irq);
      complete_run();
   end
endmodule

//--- rtl/plrt_pkg.sv
package plrt_pkg;
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned TICK_MS         = 100;
   localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned DIP_MS          = 15;
   localparam int unsigned DIP_CYCLES_DEF  = CLK_HZ / 1000 * DIP_MS;
   localparam int unsigned RAMP_STEPS      = 256;
   localparam int unsigned STEP_CYCLES_DEF = (TICK_CYCLES_DEF + RAMP_STEPS - 1) / RAMP_STEPS;

   localparam logic [7:0] ADDR_MODE    = 8'h00;
   localparam logic [7:0] ADDR_RIDE    = 8'h04;
   localparam logic [7:0] ADDR_MINOFF  = 8'h08;
   localparam logic [7:0] ADDR_RECOV   = 8'h0c;
   localparam logic [7:0] ADDR_UVTHR   = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MSK = 8'h18;
   localparam logic [7:0] ADDR_STATUS  = 8'h1c;
   localparam logic [7:0] ADDR_CTRL    = 8'h20;

   localparam logic [1:0]  MODE_OFF     = 2'h0;
   localparam logic [1:0]  MODE_TIMED   = 2'h1;
   localparam logic [1:0]  MODE_CPU     = 2'h2;
   localparam logic [1:0]  MODE_RST     = 2'h0;
   localparam logic [15:0] RIDE_RST     = 16'h0001;
   localparam logic [15:0] RIDE_MAX     = 16'h00ff;
   localparam logic [15:0] MINOFF_RST   = 16'h0002;
   localparam logic [15:0] MINOFF_MIN   = 16'h0001;
   localparam logic [15:0] MINOFF_MAX   = 16'h0032;
   localparam logic [15:0] RECOV_RST    = 16'h0003;
   localparam logic [15:0] RECOV_MAX    = 16'h0032;
   localparam logic [15:0] UVTHR_RST    = 16'h00be;
   localparam logic [15:0] UVTHR_MIN    = 16'h0096;
   localparam logic [15:0] UVTHR_MAX    = 16'h00d2;
   localparam logic [7:0]  VREF_MAX     = 8'hff;

   localparam int unsigned IRQ_FAULT   = 0;
   localparam int unsigned IRQ_DIP     = 1;
   localparam int unsigned IRQ_RESTART = 2;
   localparam int unsigned CTRL_FCLR   = 0;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_RUN    = 7'h02,
      ST_DIP    = 7'h04,
      ST_BLOCK  = 7'h08,
      ST_SEARCH = 7'h10,
      ST_RAMP   = 7'h20,
      ST_FAULT  = 7'h40
   } state_e;
endpackage

//--- rtl/power_loss_ride_through.sv
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module power_loss_ride_through
   import plrt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
   parameter int unsigned DIP_CYCLES  = DIP_CYCLES_DEF,
   parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEF,
   parameter bit          HIGH_CLASS  = 1'b0
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        run_cmd,
   input  wire logic [15:0] bus_volts,
   input  wire logic        search_done,
   input  wire logic        dc_brake_req,
   output logic             gate_enable,
   output logic             search_start,
   output logic             dc_brake_en,
   output logic [7:0]       volt_ref,
   output logic             undervolt_detect,
   output logic             main_bus_undervolt_fault,
   output logic             irq
);
   localparam int unsigned SCALE  = HIGH_CLASS ? 2 : 1;
   localparam logic [15:0] THR_RST = 16'(UVTHR_RST * SCALE);
   localparam logic [15:0] THR_MIN = 16'(UVTHR_MIN * SCALE);
   localparam logic [15:0] THR_MAX = 16'(UVTHR_MAX * SCALE);

   function automatic logic [15:0] clamp16(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   logic [1:0]  mode_q;
   logic [7:0]  ride_q;
   logic [7:0]  minoff_q;
   logic [7:0]  recov_q;
   logic [15:0] thr_q;
   logic [2:0]  irq_st_q;
   logic [2:0]  irq_msk_q;
   logic        fclr_q;
   logic        run_s1_q;
   logic        run_s2_q;
   state_e      state_q;
   state_e      state_d;
   logic [31:0] pre_q;
   logic        tick;
   logic [31:0] dip_cnt_q;
   logic [7:0]  ride_ticks_q;
   logic [7:0]  off_ticks_q;
   logic [31:0] sub_q;
   logic [7:0]  step_q;
   logic        below;
   logic        wr_acc;
   logic        rd_setup;
   logic        mapped;
   logic [2:0]  irq_ev;

   assign below    = bus_volts < thr_q;
   assign wr_acc   = psel && penable && pready && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped   = (paddr <= ADDR_CTRL) && (paddr[1:0] == 2'h0);

   // apb: one wait-free access cycle, answer registered at setup
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rd_setup)
         begin
            case (paddr)
               ADDR_MODE:    prdata <= {30'h0, mode_q};
               ADDR_RIDE:    prdata <= {24'h0, ride_q};
               ADDR_MINOFF:  prdata <= {24'h0, minoff_q};
               ADDR_RECOV:   prdata <= {24'h0, recov_q};
               ADDR_UVTHR:   prdata <= {16'h0, thr_q};
               ADDR_IRQ_ST:  prdata <= {29'h0, irq_st_q};
               ADDR_IRQ_MSK: prdata <= {29'h0, irq_msk_q};
               ADDR_STATUS:  prdata <= {16'h0, volt_ref, below, state_q};
               default:      prdata <= 32'h0;
            endcase
         end
      end

   // settings are clamped on write so the logic never sees out-of-range values
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         mode_q    <= MODE_RST;
         ride_q    <= RIDE_RST[7:0];
         minoff_q  <= MINOFF_RST[7:0];
         recov_q   <= RECOV_RST[7:0];
         thr_q     <= THR_RST;
         irq_msk_q <= 3'h0;
      end
      else if (wr_acc)
      begin
         case (paddr)
            ADDR_MODE:    mode_q    <= (pwdata[1:0] > MODE_CPU) ? MODE_CPU : pwdata[1:0];
            ADDR_RIDE:    ride_q    <= 8'(clamp16(pwdata[15:0], 16'h0, RIDE_MAX));
            ADDR_MINOFF:  minoff_q  <= 8'(clamp16(pwdata[15:0], MINOFF_MIN, MINOFF_MAX));
            ADDR_RECOV:   recov_q   <= 8'(clamp16(pwdata[15:0], 16'h0, RECOV_MAX));
            ADDR_UVTHR:   thr_q     <= clamp16(pwdata[15:0], THR_MIN, THR_MAX);
            ADDR_IRQ_MSK: irq_msk_q <= pwdata[2:0];
            default:      mode_q    <= mode_q;
         endcase
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         fclr_q <= 1'b0;
      else
         fclr_q <= wr_acc && (paddr == ADDR_CTRL) && pwdata[CTRL_FCLR];

   // run command is a terminal input, held by the source through an outage
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         run_s1_q <= 1'b0;
         run_s2_q <= 1'b0;
      end
      else
      begin
         run_s1_q <= run_cmd;
         run_s2_q <= run_s1_q;
      end

   // prescaler restarts on every state change so timed intervals are never short
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         pre_q <= 32'h0;
      else if ((state_q != state_d) || tick)
         pre_q <= 32'h0;
      else
         pre_q <= pre_q + 32'h1;

   assign tick = (pre_q == 32'(TICK_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         dip_cnt_q <= 32'h0;
      else if (!below || (state_q != ST_RUN))
         dip_cnt_q <= 32'h0;
      else if (dip_cnt_q != 32'(DIP_CYCLES))
         dip_cnt_q <= dip_cnt_q + 32'h1;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ride_ticks_q <= 8'h0;
      else if (!below)
         ride_ticks_q <= 8'h0;
      else if (tick && (state_q == ST_DIP) && (ride_ticks_q != 8'hff))
         ride_ticks_q <= ride_ticks_q + 8'h1;

   // time since the output switching was last blocked
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         off_ticks_q <= 8'h0;
      else if (gate_enable)
         off_ticks_q <= 8'h0;
      else if (tick && (off_ticks_q != 8'hff))
         off_ticks_q <= off_ticks_q + 8'h1;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (run_s2_q && !below)
               state_d = ST_RUN;
         ST_RUN:
            if (!run_s2_q)
               state_d = ST_IDLE;
            else if (below && (mode_q != MODE_OFF))
               state_d = ST_DIP;
            else if (below && (dip_cnt_q == 32'(DIP_CYCLES)))
               state_d = ST_FAULT;
         ST_DIP:
            if (below && (mode_q == MODE_TIMED) && (ride_ticks_q >= ride_q))
               state_d = ST_FAULT;
            else if (!below)
               state_d = run_s2_q ? ST_BLOCK : ST_IDLE;
         ST_BLOCK:
            if (below)
               state_d = ST_DIP;
            else if (off_ticks_q >= minoff_q)
               state_d = ST_SEARCH;
         ST_SEARCH:
            if (below)
               state_d = ST_DIP;
            else if (search_done)
               state_d = ST_RAMP;
         ST_RAMP:
            if (below)
               state_d = ST_DIP;
            else if (volt_ref == VREF_MAX)
               state_d = ST_RUN;
         ST_FAULT:
            if (fclr_q && !below)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;

   // voltage ramp: 255 steps, each recov_q sub-periods of STEP_CYCLES, a 256th of the tick
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         sub_q    <= 32'h0;
         step_q   <= 8'h0;
         volt_ref <= 8'h0;
      end
      else if (state_d == ST_RUN)
      begin
         sub_q    <= 32'h0;
         step_q   <= 8'h0;
         volt_ref <= VREF_MAX;
      end
      else if (state_q != ST_RAMP)
      begin
         sub_q    <= 32'h0;
         step_q   <= 8'h0;
         volt_ref <= 8'h0;
      end
      else if (recov_q == 8'h0)
         volt_ref <= VREF_MAX;
      else if (sub_q == 32'(STEP_CYCLES - 1))
      begin
         sub_q <= 32'h0;
         if (step_q == recov_q - 8'h1)
         begin
            step_q   <= 8'h0;
            volt_ref <= volt_ref + 8'h1;
         end
         else
            step_q <= step_q + 8'h1;
      end
      else
         sub_q <= sub_q + 32'h1;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         gate_enable              <= 1'b0;
         search_start             <= 1'b0;
         dc_brake_en              <= 1'b0;
         undervolt_detect         <= 1'b0;
         main_bus_undervolt_fault <= 1'b0;
      end
      else
      begin
         gate_enable  <= (state_d == ST_RUN) || (state_d == ST_SEARCH) || (state_d == ST_RAMP);
         search_start <= (state_q == ST_BLOCK) && (state_d == ST_SEARCH);
         // braking is only allowed once the motor flux has decayed
         dc_brake_en  <= dc_brake_req && (state_q == ST_IDLE) && !gate_enable
                         && (off_ticks_q >= minoff_q);
         undervolt_detect         <= below;
         // recovery states never drive the fault output
         main_bus_undervolt_fault <= (state_d == ST_FAULT);
      end

   assign irq_ev[IRQ_FAULT]   = (state_q != ST_FAULT) && (state_d == ST_FAULT);
   assign irq_ev[IRQ_DIP]     = (state_q == ST_RUN) && (state_d == ST_DIP);
   assign irq_ev[IRQ_RESTART] = (state_q == ST_RAMP) && (state_d == ST_RUN);

   // set wins over write-one-to-clear
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         irq_st_q <= 3'h0;
      else if (wr_acc && (paddr == ADDR_IRQ_ST))
         irq_st_q <= (irq_st_q & ~pwdata[2:0]) | irq_ev;
      else
         irq_st_q <= irq_st_q | irq_ev;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(irq_st_q & irq_msk_q);

   sequence s_dip_in_run;
      (state_q == ST_RUN) && below && run_s2_q;
   endsequence

   sequence s_back_in_time;
      (state_q == ST_DIP) && !below && run_s2_q && (ride_ticks_q < ride_q);
   endsequence

   AST_MODE0_NO_RIDE: assert property (@(posedge pclk) disable iff (!presetn)
      s_dip_in_run ##0 (mode_q == MODE_OFF) |=> state_q != ST_DIP)
      else $error("mode 0 entered ride-through");

   AST_TIMED_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
      s_back_in_time ##0 (mode_q == MODE_TIMED) |=> (state_q == ST_BLOCK) && !gate_enable)
      else $error("timed mode did not restart");

   AST_TIMED_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
      ((state_q == ST_DIP) && below && (mode_q == MODE_TIMED) && (ride_ticks_q >= ride_q))
      |=> main_bus_undervolt_fault && (state_q == ST_FAULT))
      else $error("timed mode outage did not fault");

   AST_CPU_NO_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
      ((state_q == ST_DIP) && (mode_q == MODE_CPU)) |=> state_q != ST_FAULT)
      else $error("mode 2 raised undervoltage fault");

   AST_RIDE_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      ride_q <= RIDE_MAX[7:0] && (minoff_q >= MINOFF_MIN[7:0]) && (minoff_q <= MINOFF_MAX[7:0]))
      else $error("timing setting out of range");

   AST_MIN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(search_start) |-> !$past(gate_enable) && ($past(off_ticks_q) >= $past(minoff_q)))
      else $error("search started before minimum off time");

   AST_RAMP_FROM_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      ((state_q == ST_SEARCH) && (state_d == ST_RAMP) && (recov_q != 8'h0))
      |=> (volt_ref == 8'h0) [*2])
      else $error("ramp did not start at zero");

   AST_UV_COMPARE: assert property (@(posedge pclk) disable iff (!presetn)
      (bus_volts < thr_q) |=> undervolt_detect)
      else $error("undervoltage not detected");

   AST_THR_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      (thr_q >= THR_MIN) && (thr_q <= THR_MAX))
      else $error("threshold outside class range");

   AST_NO_FAULT_RECOVER: assert property (@(posedge pclk) disable iff (!presetn)
      ((state_q == ST_DIP) || (state_q == ST_BLOCK) || (state_q == ST_SEARCH)
       || (state_q == ST_RAMP)) |-> !main_bus_undervolt_fault)
      else $error("fault output active during recovery");

   AST_MODE0_15MS: assert property (@(posedge pclk) disable iff (!presetn)
      s_dip_in_run ##0 ((mode_q == MODE_OFF) && (dip_cnt_q == 32'(DIP_CYCLES)))
      |=> main_bus_undervolt_fault)
      else $error("mode 0 dip did not fault");

   AST_BRAKE_OFF_TIME: assert property (@(posedge pclk) disable iff (!presetn)
      dc_brake_en |-> $past(off_ticks_q) >= $past(minoff_q))
      else $error("braking before minimum off time");

   AST_RIDE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      !below |=> ride_ticks_q == 8'h0)
      else $error("ride timer not cleared");
endmodule
